//--- hw/bit_logic_unit.sv
module bit_logic_unit (
  input wire logic ref_clk_in, // 10 MHz clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic [1:0] variant_in, // Processor variant strap pins
  input bit_logic_pkg::instr_s instr_in, // Instruction, one per cycle
  input bit_logic_pkg::bit_wr_s image_wr_in, // Image loader writes
  output logic logic_result_bit_out, // Current logic result
  output logic first_scan_out, // Next scan loads
  output logic [3:0] stack_depth_out, // Open groups
  output bit_logic_pkg::bit_wr_s assign_out, // Assignment write pulse
  output logic done_out, // Instruction executed pulse
  output logic overflow_err_out, // Group stack overflow pulse
  output logic unmatched_err_out, // Unmatched close pulse
  output logic range_err_out // Operand out of range, or assignment to timer/counter, pulse
);
  import bit_logic_pkg::*;

  // Reset synchroniser; release is clocked, assertion is immediate
  logic rst_q1, rst_q2;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end
  wire rst_n = rst_q2; // Synchronised reset

  // Variant strap passes two flip-flops
  logic [1:0] var_q1, variant_q;
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      var_q1 <= VARIANT_RESET;
      variant_q <= VARIANT_RESET;
    end else begin
      var_q1 <= variant_in;
      variant_q <= var_q1;
    end
  end

  // Operand images; data only, so no reset (loader fills them)
  logic input_img [0:1023];
  logic output_img [0:1023];
  logic flag_img [0:2047];
  logic timer_img [0:127];
  logic counter_img [0:127];

  // Control state
  scan_e state_q, state_d;
  logic chain_q, chain_d; // Value of the current AND chain
  logic or_acc_q, or_acc_d; // OR of earlier chains
  logic or_active_q, or_active_d; // A bare OR is pending
  logic [PTR_W-1:0] sp_q, sp_d; // Stack pointer
  frame_s stack_q [0:STACK_DEPTH-1]; // Saved group contexts
  logic result_q; // Registered logic result

  // Decode
  wire op_e op = instr_in.op;
  wire operand_s opnd = instr_in.operand;
  wire is_scan = instr_in.valid && (op == OP_SCAN_AND || op == OP_SCAN_OR ||
    op == OP_INVERTED_TEST_WITH_PRODUCT || op == OP_INVERTED_TEST_WITH_SUM);
  wire is_open = instr_in.valid && (op == OP_OPEN_AND || op == OP_OPEN_OR);
  wire is_close = instr_in.valid && (op == OP_CLOSE);
  wire is_orch = instr_in.valid && (op == OP_OR_CHAIN);
  wire is_assign = instr_in.valid && (op == OP_ASSIGN);
  wire needs_opnd = is_scan || is_assign;
  wire opnd_ok = in_range(opnd, variant_q);
  wire range_bad = needs_opnd && !opnd_ok;
  // Assignments only into writable bit areas
  wire assign_area_ok = (opnd.area == AREA_OUTPUT) || (opnd.area == AREA_FLAG) || (opnd.area == AREA_INPUT);
  wire overflow = is_open && (sp_q == PTR_FULL);
  wire unmatched = is_close && (sp_q == PTR_RESET);

  // Bit indexes into the images
  wire [9:0] io_idx = {opnd.byte_idx[6:0], opnd.bit_idx};
  wire [10:0] flag_idx = {opnd.byte_idx, opnd.bit_idx};
  wire [6:0] tc_idx = opnd.byte_idx[6:0];

  // Addressed operand bit
  wire opnd_bit = (opnd.area == AREA_INPUT) ? input_img[io_idx] :
                  (opnd.area == AREA_OUTPUT) ? output_img[io_idx] :
                  (opnd.area == AREA_FLAG) ? flag_img[flag_idx] :
                  (opnd.area == AREA_TIMER) ? timer_img[tc_idx] :
                  (opnd.area == AREA_COUNTER) ? counter_img[tc_idx] : 1'b0;

  // Scan result: inverted forms test for zero
  wire scan_inv = (op == OP_INVERTED_TEST_WITH_PRODUCT) || (op == OP_INVERTED_TEST_WITH_SUM);
  wire scan_res = opnd_bit ^ scan_inv;
  wire scan_is_or = (op == OP_SCAN_OR) || (op == OP_INVERTED_TEST_WITH_SUM);
  wire first = (state_q == SCAN_FIRST);

  // Effective result: open OR chains folded in
  wire eff = chain_q | (or_active_q & or_acc_q);
  wire frame_s top = stack_q[(sp_q == PTR_RESET) ? 3'h0 : 3'(sp_q - 4'h1)];
  // Group result merged into the outer chain; a group at first scan loads
  wire closed_val = combine(top.first, top.chain, eff, top.grp_or);

  // Next-state logic
  always_comb begin
    state_d = state_q;
    chain_d = chain_q;
    or_acc_d = or_acc_q;
    or_active_d = or_active_q;
    sp_d = sp_q;
    if (is_scan && !range_bad) begin
      chain_d = combine(first, chain_q, scan_res, scan_is_or);
      state_d = SCAN_CHAIN;
    end else if (is_orch) begin
      // Next AND chain evaluated alone, then ORed
      or_acc_d = eff;
      or_active_d = 1'b1;
      state_d = SCAN_FIRST;
    end else if (is_open && !overflow) begin
      // Fresh sub-expression
      sp_d = sp_q + 4'h1;
      or_active_d = 1'b0;
      state_d = SCAN_FIRST;
    end else if (is_close && !unmatched) begin
      // Restore outer context
      sp_d = sp_q - 4'h1;
      chain_d = closed_val;
      or_acc_d = top.or_acc;
      or_active_d = top.or_active;
      state_d = SCAN_CHAIN;
    end else if (is_assign && !range_bad) begin
      // Assignment limits the result
      chain_d = eff;
      or_active_d = 1'b0;
      state_d = SCAN_FIRST;
    end
  end

  // Control registers
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SCAN_FIRST;
      chain_q <= RESULT_RESET;
      or_acc_q <= RESULT_RESET;
      or_active_q <= 1'b0;
      sp_q <= PTR_RESET;
    end else begin
      state_q <= state_d;
      chain_q <= chain_d;
      or_acc_q <= or_acc_d;
      or_active_q <= or_active_d;
      sp_q <= sp_d;
    end
  end

  // Push a frame when a group opens; recorded op chosen here
  always_ff @(posedge ref_clk_in) begin
    if (is_open && !overflow) begin
      stack_q[sp_q[2:0]] <= '{chain: chain_q, first: first, or_acc: or_acc_q,
                              or_active: or_active_q, grp_or: (op == OP_OPEN_OR)};
    end
  end

  // Image writes; an assignment overrides a loader write in the same cycle
  wire do_assign = is_assign && !range_bad && assign_area_ok;
  always_ff @(posedge ref_clk_in) begin
    if (image_wr_in.valid) begin
      unique case (image_wr_in.operand.area)
        AREA_INPUT: input_img[{image_wr_in.operand.byte_idx[6:0], image_wr_in.operand.bit_idx}] <= image_wr_in.value;
        AREA_OUTPUT: output_img[{image_wr_in.operand.byte_idx[6:0], image_wr_in.operand.bit_idx}] <= image_wr_in.value;
        AREA_FLAG: flag_img[{image_wr_in.operand.byte_idx, image_wr_in.operand.bit_idx}] <= image_wr_in.value;
        AREA_TIMER: timer_img[image_wr_in.operand.byte_idx[6:0]] <= image_wr_in.value;
        AREA_COUNTER: counter_img[image_wr_in.operand.byte_idx[6:0]] <= image_wr_in.value;
        default: ;
      endcase
    end
    if (do_assign) begin
      // Assignment stores the current result every time
      if (opnd.area == AREA_OUTPUT) begin
        output_img[io_idx] <= eff;
      end else if (opnd.area == AREA_FLAG) begin
        flag_img[flag_idx] <= eff;
      end else begin
        input_img[io_idx] <= eff;
      end
    end
  end

  // Registered outputs and one-cycle pulses
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= RESULT_RESET;
      assign_out <= '0;
      done_out <= 1'b0;
      overflow_err_out <= 1'b0;
      unmatched_err_out <= 1'b0;
      range_err_out <= 1'b0;
    end else begin
      result_q <= chain_d | (or_active_d & or_acc_d);
      assign_out <= '{valid: do_assign, operand: opnd, value: eff};
      done_out <= instr_in.valid && !range_bad && !overflow && !unmatched;
      overflow_err_out <= overflow;
      unmatched_err_out <= unmatched;
      range_err_out <= range_bad || (is_assign && !assign_area_ok);
    end
  end

  assign logic_result_bit_out = result_q;
  assign first_scan_out = first;
  assign stack_depth_out = sp_q;

  // Checks
  a_and_scan_result: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (instr_in.valid && op == OP_SCAN_AND && !range_bad && !first) |=> (chain_q == ($past(chain_q) & $past(opnd_bit))))
    else $error("AND scan result wrong");
  a_or_scan_result: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (instr_in.valid && op == OP_SCAN_OR && !range_bad && !first) |=> (chain_q == ($past(chain_q) | $past(opnd_bit))))
    else $error("OR scan result wrong");
  a_inv_and_scan: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (instr_in.valid && op == OP_INVERTED_TEST_WITH_PRODUCT && !range_bad && !first)
    |=> (chain_q == ($past(chain_q) & !$past(opnd_bit))))
    else $error("Inverted AND scan wrong");
  a_inv_or_scan: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (instr_in.valid && op == OP_INVERTED_TEST_WITH_SUM && !range_bad && !first)
    |=> (chain_q == ($past(chain_q) | !$past(opnd_bit))))
    else $error("Inverted OR scan wrong");
  a_first_scan_load: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (is_scan && !range_bad && first) |=> (chain_q == $past(scan_res)) && !first_scan_out)
    else $error("First scan did not load");
  a_or_chain_fold: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    is_orch |=> (or_acc_q == $past(eff)) && or_active_q && first_scan_out)
    else $error("Bare OR did not fold chain");
  a_group_push: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (is_open && !overflow) |=> (stack_depth_out == $past(sp_q) + 4'h1) && first_scan_out)
    else $error("Group open did not push");
  a_group_close: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (is_close && !unmatched) |=> (chain_q == $past(closed_val)) && (stack_depth_out == $past(sp_q) - 4'h1))
    else $error("Group close combine wrong");
  a_assign_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    do_assign |=> assign_out.valid && (assign_out.value == $past(eff)) ##1 !assign_out.valid || $past(do_assign))
    else $error("Assignment write missing");
  a_stack_errors: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    (overflow || unmatched) |=> (overflow_err_out || unmatched_err_out) && (stack_depth_out == $past(sp_q)))
    else $error("Stack error not flagged");
  a_assign_first: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    do_assign |=> first_scan_out && !or_active_q)
    else $error("Assignment left chain open");
  a_range_reject: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
    range_bad |=> range_err_out && $stable(chain_q) && !assign_out.valid)
    else $error("Out of range operand used");

  c_and_chain: cover property (@(posedge ref_clk_in) disable iff (!rst_n) is_scan ##1 is_scan ##1 is_assign);
  c_or_group: cover property (@(posedge ref_clk_in) disable iff (!rst_n)
    (instr_in.valid && op == OP_OPEN_OR) ##[1:4] is_scan ##[1:4] is_close);
  c_bare_or: cover property (@(posedge ref_clk_in) disable iff (!rst_n) is_orch ##1 is_scan ##1 is_assign);
  c_overflow: cover property (@(posedge ref_clk_in) disable iff (!rst_n) overflow);
endmodule

//--- hw/bit_logic_pkg.sv
// How it works
// - AND scan tests bit for one, ANDs
// - OR scan tests bit for one, ORs
// - Inverted AND scan tests for zero, ANDs
// - Inverted OR scan tests for zero, ORs
// - First scan after limiting operation loads result
// - Bare OR closes AND chain, ORs later
// - AND group saves result, ANDs on close
// - OR group saves result, ORs on close
// - Close combines innermost group using recorded operation
// - Bit operands byte.bit, flags reach 255 on the big variant, 127 otherwise
// - Timer, counter status numbered per variant
// - Assignment writes result to input, output or flag operand bit
package bit_logic_pkg;
  // Stack sizing; eight frames cover eight nesting levels
  localparam int STACK_DEPTH = 8;
  localparam int PTR_W = 4;
  localparam logic [PTR_W-1:0] PTR_FULL = 4'h8;
  localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
  // Operand ranges
  localparam logic [7:0] IO_BYTE_MAX = 8'h7f;
  localparam logic [7:0] FLAG_BYTE_MAX_BIG = 8'hff;
  localparam logic [7:0] TC_MAX_SMALL = 8'h0f;
  localparam logic [7:0] TC_MAX_MID = 8'h1f;
  localparam logic [7:0] TC_MAX_BIG = 8'h7f;
  // Processor variant codes on the strap pins
  localparam logic [1:0] VAR_SMALL = 2'h0;
  localparam logic [1:0] VAR_MID = 2'h1;
  localparam logic [1:0] VAR_BIG = 2'h2;
  localparam logic [1:0] VARIANT_RESET = 2'h0;
  // Values after reset
  localparam logic RESULT_RESET = 1'b0;
  // Instruction codes
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_SCAN_AND = 4'h1,
    OP_SCAN_OR = 4'h2,
    OP_INVERTED_TEST_WITH_PRODUCT = 4'h3,
    OP_INVERTED_TEST_WITH_SUM = 4'h4,
    OP_OR_CHAIN = 4'h5,
    OP_OPEN_AND = 4'h6,
    OP_OPEN_OR = 4'h7,
    OP_CLOSE = 4'h8,
    OP_ASSIGN = 4'h9
  } op_e;
  // Operand areas
  typedef enum logic [2:0] {
    AREA_INPUT = 3'h0,
    AREA_OUTPUT = 3'h1,
    AREA_FLAG = 3'h2,
    AREA_TIMER = 3'h3,
    AREA_COUNTER = 3'h4
  } area_e;
  // Scan state, Gray coded
  typedef enum logic [1:0] {
    SCAN_FIRST = 2'b00,
    SCAN_CHAIN = 2'b01
  } scan_e;
  typedef struct packed {
    area_e area;
    logic [7:0] byte_idx; // Byte, or timer/counter number
    logic [2:0] bit_idx;
  } operand_s;
  typedef struct packed {
    logic valid;
    op_e op;
    operand_s operand;
  } instr_s;
  typedef struct packed {
    logic valid;
    operand_s operand;
    logic value;
  } bit_wr_s;
  // One saved group context
  typedef struct packed {
    logic chain;
    logic first;
    logic or_acc;
    logic or_active;
    logic grp_or;
  } frame_s;

  // Load on first scan, else AND or OR into old value
  function automatic logic combine(input logic first, input logic old, input logic s, input logic is_or);
    combine = first ? s : (is_or ? (old | s) : (old & s));
  endfunction

  // Operand within the limits of the given variant
  function automatic logic in_range(input operand_s o, input logic [1:0] variant);
    logic [7:0] tc_max;
    logic [7:0] flag_max;
    tc_max = (variant == VAR_BIG) ? TC_MAX_BIG : ((variant == VAR_MID) ? TC_MAX_MID : TC_MAX_SMALL);
    flag_max = (variant == VAR_BIG) ? FLAG_BYTE_MAX_BIG : IO_BYTE_MAX;
    unique case (o.area)
      AREA_INPUT, AREA_OUTPUT: in_range = (o.byte_idx <= IO_BYTE_MAX);
      AREA_FLAG: in_range = (o.byte_idx <= flag_max);
      AREA_TIMER, AREA_COUNTER: in_range = (o.byte_idx <= tc_max);
      default: in_range = 1'b0;
    endcase
  endfunction
endpackage

//--- sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bit_logic_pkg::*;

  logic ref_clk_in; // Bench clock, 10 MHz
  logic rst_n_in; // Active-low reset
  logic [1:0] variant_in; // Variant strap
  instr_s instr_in; // Instruction stream
  bit_wr_s image_wr_in; // Image preload port
  logic logic_result_bit_out;
  logic first_scan_out;
  logic [3:0] stack_depth_out;
  bit_wr_s assign_out;
  logic done_out;
  logic overflow_err_out;
  logic unmatched_err_out;
  logic range_err_out;
  int n_fail; // Mismatches seen
  int tests_run; // Comparisons made

  bit_logic_unit bit_logic_unit_inst (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .variant_in(variant_in),
    .instr_in(instr_in),
    .image_wr_in(image_wr_in),
    .logic_result_bit_out(logic_result_bit_out),
    .first_scan_out(first_scan_out),
    .stack_depth_out(stack_depth_out),
    .assign_out(assign_out),
    .done_out(done_out),
    .overflow_err_out(overflow_err_out),
    .unmatched_err_out(unmatched_err_out),
    .range_err_out(range_err_out)
  );

  // Free-running clock, 100 ns period
  always #50 ref_clk_in = ~ref_clk_in;

  // One-bit comparison, four-state exact
  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // Stack depth comparison
  task automatic chk_cnt(input logic [3:0] got, input logic [3:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // Issue one instruction; also drops any loader write left high
  task automatic send(input op_e op, input area_e a = AREA_INPUT, input logic [7:0] b = 8'h00,
                      input logic [2:0] i = 3'h0);
    @(posedge ref_clk_in);
    image_wr_in.valid <= 1'b0;
    instr_in <= '{1'b1, op, '{a, b, i}};
  endtask

  // Stop issuing; outputs of the last instruction are settled on return
  task automatic idle();
    @(posedge ref_clk_in);
    instr_in.valid <= 1'b0;
    #1;
  endtask

  // Preload one image bit
  task automatic wimg(input logic [2:0] i, input logic v);
    @(posedge ref_clk_in);
    image_wr_in <= '{1'b1, '{AREA_INPUT, 8'h00, i}, v};
  endtask

  // Assign to Q1.0 and check the written value
  task automatic assign_chk(input logic exp, input string what);
    send(OP_ASSIGN, AREA_OUTPUT, 8'h01, 3'h0);
    idle();
    chk_bit(assign_out.valid, 1'b1, what);
    chk_bit(assign_out.value, exp, what);
    chk_bit(logic_result_bit_out, exp, "result kept after assign");
    chk_bit(first_scan_out, 1'b1, "first scan after assign");
  endtask

  // All four scan kinds, as first scan and as combining scan
  task automatic t_scans();
    op_e op;
    logic sc;
    wimg(3'h0, 1'b0);
    wimg(3'h1, 1'b1);
    for (int k = 1; k <= 4; k++) begin
      for (int o = 0; o < 2; o++) begin
        for (int v = 0; v < 2; v++) begin
          op = op_e'(k);
          // Bit picked so the loading scan yields o
          send(op, AREA_INPUT, 8'h00, (k >= 3) ? 3'(1 - o) : 3'(o));
          send(op, AREA_INPUT, 8'h00, 3'(v));
          sc = (k >= 3) ? !v[0] : v[0];
          assign_chk((k == 1 || k == 3) ? (o[0] & sc) : (o[0] | sc), "scan combine");
        end
      end
    end
    $display("test scans done");
  endtask

  // AND before OR, and grouped expressions, over all input patterns
  task automatic t_groups();
    logic [3:0] p;
    for (int n = 0; n < 16; n++) begin
      p = 4'(n);
      for (int i = 0; i < 4; i++) wimg(3'(i), p[i]);
      send(OP_SCAN_AND, AREA_INPUT, 8'h00, 3'h0);
      send(OP_SCAN_AND, AREA_INPUT, 8'h00, 3'h1);
      send(OP_OR_CHAIN);
      send(OP_SCAN_AND, AREA_INPUT, 8'h00, 3'h2);
      send(OP_SCAN_AND, AREA_INPUT, 8'h00, 3'h3);
      assign_chk((p[0] & p[1]) | (p[2] & p[3]), "and before or");
      send(OP_OPEN_AND);
      send(OP_SCAN_OR, AREA_INPUT, 8'h00, 3'h0);
      send(OP_SCAN_OR, AREA_INPUT, 8'h00, 3'h1);
      send(OP_CLOSE);
      send(OP_OPEN_AND);
      send(OP_SCAN_OR, AREA_INPUT, 8'h00, 3'h2);
      send(OP_SCAN_OR, AREA_INPUT, 8'h00, 3'h3);
      send(OP_CLOSE);
      assign_chk((p[0] | p[1]) & (p[2] | p[3]), "or before and");
      send(OP_SCAN_AND, AREA_INPUT, 8'h00, 3'h0);
      send(OP_OPEN_OR);
      send(OP_SCAN_AND, AREA_INPUT, 8'h00, 3'h1);
      send(OP_SCAN_AND, AREA_INPUT, 8'h00, 3'h2);
      send(OP_CLOSE);
      assign_chk(p[0] | (p[1] & p[2]), "or group");
    end
    $display("test groups done");
  endtask

  // Fill the group stack past its depth, then close past empty
  task automatic t_stack();
    for (int i = 0; i < 8; i++) send(OP_OPEN_AND);
    idle();
    chk_cnt(stack_depth_out, 4'h8, "depth full");
    send(OP_OPEN_OR);
    idle();
    chk_bit(overflow_err_out, 1'b1, "overflow");
    chk_cnt(stack_depth_out, 4'h8, "depth kept");
    for (int i = 0; i < 8; i++) send(OP_CLOSE);
    idle();
    chk_cnt(stack_depth_out, 4'h0, "depth empty");
    chk_bit(unmatched_err_out, 1'b0, "no unmatched");
    send(OP_CLOSE);
    idle();
    chk_bit(unmatched_err_out, 1'b1, "unmatched close");
    chk_bit(done_out, 1'b0, "no done on refused close");
    $display("test stack done");
  endtask

  // One operand range probe under a given variant
  task automatic rng(input logic [1:0] v, input area_e a, input logic [7:0] b, input logic e);
    if (variant_in !== v) begin
      @(posedge ref_clk_in);
      variant_in <= v;
      repeat (4) @(posedge ref_clk_in);
    end
    // Preload the probed bit so the scan never reads an unloaded image
    @(posedge ref_clk_in);
    image_wr_in <= '{1'b1, '{a, b, 3'h7}, 1'b0};
    send(OP_SCAN_AND, a, b, 3'h7);
    idle();
    chk_bit(range_err_out, e, "operand range");
  endtask

  // Operand limits per variant
  task automatic t_range();
    rng(VAR_SMALL, AREA_INPUT, 8'h7f, 1'b0);
    rng(VAR_SMALL, AREA_OUTPUT, 8'h80, 1'b1);
    rng(VAR_SMALL, AREA_FLAG, 8'h80, 1'b1);
    rng(VAR_SMALL, AREA_TIMER, 8'h0f, 1'b0);
    rng(VAR_SMALL, AREA_COUNTER, 8'h10, 1'b1);
    rng(VAR_MID, AREA_TIMER, 8'h1f, 1'b0);
    rng(VAR_MID, AREA_COUNTER, 8'h20, 1'b1);
    rng(VAR_BIG, AREA_FLAG, 8'hff, 1'b0);
    rng(VAR_BIG, AREA_INPUT, 8'h80, 1'b1);
    rng(VAR_BIG, AREA_COUNTER, 8'h7f, 1'b0);
    rng(VAR_BIG, AREA_TIMER, 8'h80, 1'b1);
    $display("test range done");
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence: reset, idle state, then scenarios
  initial begin
    ref_clk_in = 1'b0;
    rst_n_in = 1'b0;
    variant_in = VAR_SMALL;
    instr_in = '0;
    image_wr_in = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (3) @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    #1;
    chk_bit(first_scan_out, 1'b1, "first scan at reset");
    chk_bit(logic_result_bit_out, 1'b0, "result at reset");
    chk_cnt(stack_depth_out, 4'h0, "depth at reset");
    @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    t_scans();
    t_groups();
    t_stack();
    t_range();
    complete_run();
  end
endmodule
